// ==== bench/tb.sv ====
module tb
  import vin_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // field is kept short so that whole fields fit in the run
  localparam int ACT_LINES = 5;

  typedef struct {
    int    stall;
    beat_t exp;
  } row_t;

  logic             clk_i;
  logic             rst_n_i;
  logic             start_i;
  logic             vo_ready_i;
  logic             pix_clk_i;
  logic [PIX_W-1:0] pix_data;
  logic             src_fid;
  logic             src_vbl;
  logic             vo_valid_o;
  beat_t            vo_beat_o;
  beat_t            b;
  logic             fid;
  int               miscompares;
  int               compares;
  int               n;
  row_t             rows[6];

  video_in_clipper #(.FIFO_AW(11)) DUT (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .start_i    (start_i),
    .vo_beat_o  (vo_beat_o),
    .vo_valid_o (vo_valid_o),
    .vo_ready_i (vo_ready_i),
    .pix_clk_i  (pix_clk_i),
    .pix_data_i (pix_data)
  );

  vdec_model #(.ACT(ACT_LINES)) u_src (
    .pix_clk_i  (pix_clk_i),
    .pix_data_o (pix_data),
    .fid_o      (src_fid),
    .vbl_o      (src_vbl)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial
  begin
    pix_clk_i = 1'b0;
    #7;
    forever #16 pix_clk_i = ~pix_clk_i;
  end

  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  task automatic wait_vbl(input logic v);
    int w;
    w = 0;
    while (src_vbl !== v)
    begin
      tick();
      w++;
      if (w > 40000)
      begin
        miscompares++;
        final_report();
      end
    end
  endtask

  // waits for a beat, holds ready low for stall cycles, then takes it
  task automatic get_beat(input int stall);
    int w;
    vo_ready_i = (stall == 0);
    w = 0;
    while (vo_valid_o !== 1'b1)
    begin
      tick();
      w++;
      if (w > 30000)
      begin
        miscompares++;
        final_report();
      end
    end
    b = vo_beat_o;
    if (stall > 0)
    begin
      repeat (stall)
      begin
        tick();
        chk(vo_beat_o, b);
        chk({9'h0, vo_valid_o}, 10'h1);
      end
      vo_ready_i = 1'b1;
    end
    tick();
  endtask

  task automatic field_hdr(input logic f);
    rows[0] = '{0, beat_t'{1'b1, 1'b0, CTRL_TYPE}};
    rows[1] = '{3, beat_t'{1'b0, 1'b0, OUT_WIDTH[15:8]}};
    rows[2] = '{0, beat_t'{1'b0, 1'b0, OUT_WIDTH[7:0]}};
    rows[3] = '{2, beat_t'{1'b0, 1'b0, OUT_HEIGHT}};
    rows[4] = '{0, beat_t'{1'b0, 1'b1, {7'h0, f}}};
    rows[5] = '{1, beat_t'{1'b1, 1'b0, DATA_TYPE}};
    foreach (rows[i])
    begin
      get_beat(rows[i].stall);
      chk(b, rows[i].exp);
    end
  endtask

  initial
  begin
    miscompares = 0;
    compares = 0;
    rst_n_i = 1'b0;
    start_i = 1'b0;
    vo_ready_i = 1'b1;
    repeat (5) tick();
    chk(vo_beat_o, 10'h000);
    chk({9'h0, vo_valid_o}, 10'h0);
    rst_n_i = 1'b1;
    // a whole field goes by with the input stage not yet started
    repeat (12000)
    begin
      tick();
      chk({9'h0, vo_valid_o}, 10'h0);
    end
    $display("test idle done");
    wait_vbl(1'b0);
    wait_vbl(1'b1);
    fid = src_fid;
    start_i = 1'b1;
    field_hdr(fid);
    // first sample out must be line three's first, untouched
    for (int l = CLIP_TOP; l < ACT_LINES; l++)
      for (int k = 0; k < LINE_SAMPLES; k++)
      begin
        get_beat((k == 7) ? 3 : 0);
        chk(b, {2'b00, 8'h10 + 8'((l * 37 + k) % 224)});
      end
    get_beat(0);
    chk(b, {2'b01, PAD_SAMPLE});
    $display("test field done");
    field_hdr(~fid);
    // long stall overflows the crossing buffer mid field
    vo_ready_i = 1'b0;
    repeat (9000) tick();
    n = 0;
    b = '0;
    while (b.eop !== 1'b1 && n < 4000)
    begin
      get_beat(0);
      n++;
    end
    chk(b, {2'b01, PAD_SAMPLE});
    chk({9'h0, 1'(n <= 2 * LINE_SAMPLES)}, 10'h1);
    $display("test overflow done");
    field_hdr(fid);
    $display("test resync done");
    final_report();
  end
endmodule

// ==== bench/vdec_model.sv ====
module vdec_model #(
  parameter int HBL = 1000,
  parameter int VBL = 2,
  parameter int ACT = 5
) (
  // link
  input  wire logic pix_clk_i,
  output logic [7:0] pix_data_o,
  // field state seen by the bench
  output logic       fid_o,
  output logic       vbl_o
);
  timeunit 1ns;
  timeprecision 100ps;

  task automatic put(input logic [7:0] v);
    @(posedge pix_clk_i);
    #2;
    pix_data_o = v;
  endtask

  // code prefix, then flags with their protection bits
  task automatic trs(input logic h);
    put(8'hFF);
    put(8'h00);
    put(8'h00);
    put({1'b1, fid_o, vbl_o, h, vbl_o ^ h, fid_o ^ h,
         fid_o ^ vbl_o, fid_o ^ vbl_o ^ h});
  endtask

  initial
  begin
    pix_data_o = 8'h80;
    fid_o = 1'b0;
    vbl_o = 1'b0;
    forever
    begin
      fid_o = ~fid_o;
      for (int l = -VBL; l < ACT; l++)
      begin
        vbl_o = (l < 0);
        trs(1'b1);
        // long blanking lets the slower system side drain each line
        for (int i = 0; i < HBL; i++)
          put(i[0] ? 8'h10 : 8'h80);
        trs(1'b0);
        for (int k = 0; k < 1440; k++)
          put(vbl_o ? 8'h80 : 8'h10 + 8'((l * 37 + k) % 224));
      end
    end
  end
endmodule

// ==== rtl/video_in_clipper.sv ====
// Operation
// - 8-bit interlaced 4:2:2 stream, embedded sync
// - accept 720 pixels, 244/243 line fields
// - samples serial in Cb Y Cr Y order
// - discard all horizontal and vertical blanking
// - control packet then active packet per field
// - active samples pass through unmodified
// - cross pixel clock into unrelated system clock
// - output moves only when downstream ready
// - clip 720x240 starting three lines down
module video_in_clipper
  import vin_pkg::*;
#(
  parameter int FIFO_AW = 11
) (
  // system clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // host control
  input  wire logic             start_i,
  // output stream
  output beat_t                 vo_beat_o,
  output logic                  vo_valid_o,
  input  wire logic             vo_ready_i,
  // clocked video link
  input  wire logic             pix_clk_i,
  input  wire logic [PIX_W-1:0] pix_data_i
);

  // ---------------- link domain ----------------
  logic             rst_meta, link_rst_n, start_meta, start_sync;
  logic [PIX_W-1:0] b0, b1, b2, b3;
  logic [2:0]       sav_pipe;
  logic             active_reg, vblank_reg, open_reg, field_reg;
  logic             trs_now, sav_now, field_start, field_end;
  logic             wr_valid, wr_ready;
  link_word_t       wr_word;

  // reset is carried into the link clock; release is seen two edges later
  always_ff @(posedge pix_clk_i)
  begin
    rst_meta   <= rst_n_i;
    link_rst_n <= rst_meta;
  end

  always_ff @(posedge pix_clk_i)
  begin
    if (!link_rst_n)
    begin
      start_meta <= 1'b0;
      start_sync <= 1'b0;
    end
    else
    begin
      start_meta <= start_i;
      start_sync <= start_meta;
    end
  end

  // pixel byte history; b3 is the oldest and the one that gets pushed
  always_ff @(posedge pix_clk_i)
  begin
    if (!link_rst_n)
    begin
      {b0, b1, b2, b3} <= '0;
    end
    else
    begin
      b0 <= pix_data_i;
      b1 <= b0;
      b2 <= b1;
      b3 <= b2;
    end
  end

  assign trs_now     = b3 == TRS_ONES && b2 == TRS_ZEROS && b1 == TRS_ZEROS;
  assign sav_now     = trs_now && !b0[XY_H] && !b0[XY_V];
  assign field_start = sav_now && vblank_reg;
  assign field_end   = trs_now && b0[XY_H] && b0[XY_V] && !vblank_reg;

  always_ff @(posedge pix_clk_i)
  begin
    if (!link_rst_n)
    begin
      sav_pipe   <= '0;
      active_reg <= 1'b0;
      vblank_reg <= 1'b1;
      field_reg  <= 1'b0;
    end
    else
    begin
      sav_pipe <= {sav_pipe[1:0], sav_now};
      if (trs_now)
      begin
        active_reg <= 1'b0;
        field_reg  <= b0[XY_F];
        // v already flips on the line-end code, so only line starts update it;
        // otherwise the first active line start never sees the blanking before it
        if (!b0[XY_H])
        begin
          vblank_reg <= b0[XY_V];
        end
      end
      else if (sav_pipe[2])
      begin
        active_reg <= 1'b1;
      end
    end
  end

  // the host start is a level; capture only begins at a whole field
  always_comb
  begin
    wr_valid = 1'b0;
    wr_word  = '{kind: K_SAMPLE, fid: field_reg, data: b3};
    if (field_start && start_sync)
    begin
      wr_valid     = 1'b1;
      wr_word.kind = K_START;
      wr_word.fid  = b0[XY_F];
    end
    else if (field_end && open_reg)
    begin
      wr_valid     = 1'b1;
      wr_word.kind = K_END;
    end
    else if (active_reg && open_reg && !trs_now)
    begin
      wr_valid = 1'b1;
    end
  end

  always_ff @(posedge pix_clk_i)
  begin
    if (!link_rst_n)
    begin
      open_reg <= 1'b0;
    end
    else if (field_start && start_sync)
    begin
      open_reg <= wr_ready;
    end
    else if (field_end || (wr_valid && !wr_ready))
    begin
      open_reg <= 1'b0;
    end
  end

  // ---------------- crossing ----------------
  logic       rd_valid, pop;
  link_word_t rd_word;

  vin_cdc_fifo #(
    .W  ($bits(link_word_t)),
    .AW (FIFO_AW)
  ) u_fifo (
    .wr_clk_i   (pix_clk_i),
    .wr_rst_n_i (link_rst_n),
    .wr_valid_i (wr_valid),
    .wr_data_i  (wr_word),
    .wr_ready_o (wr_ready),
    .rd_clk_i   (clk_i),
    .rd_rst_n_i (rst_n_i),
    .rd_valid_o (rd_valid),
    .rd_data_o  (rd_word),
    .rd_ready_i (pop)
  );

  // ---------------- system domain ----------------
  sys_state_t  state_reg;
  logic [2:0]  ctrl_idx;
  logic [7:0]  line_cnt;
  logic [10:0] pix_cnt;
  logic        fid_reg, load, emit, in_clip, last_kept, is_sample;
  logic        vo_valid_reg;
  beat_t       vo_beat_reg, beat_next;
  logic [7:0]  ctrl_byte;

  assign load      = !vo_valid_reg || vo_ready_i;
  assign is_sample = rd_word.kind == K_SAMPLE;
  assign in_clip   = line_cnt >= 8'(CLIP_TOP) && line_cnt <= 8'(CLIP_LAST)
                     && pix_cnt < 11'(CLIP_SAMPLES);
  assign last_kept = line_cnt == 8'(CLIP_LAST) && pix_cnt == 11'(CLIP_SAMPLES - 1);

  always_comb
  begin
    case (ctrl_idx)
      3'h0:    ctrl_byte = CTRL_TYPE;
      3'h1:    ctrl_byte = OUT_WIDTH[15:8];
      3'h2:    ctrl_byte = OUT_WIDTH[7:0];
      3'h3:    ctrl_byte = OUT_HEIGHT;
      default: ctrl_byte = {7'h00, fid_reg};
    endcase
  end

  always_comb
  begin
    pop       = 1'b0;
    emit      = 1'b0;
    beat_next = '0;
    case (state_reg)
      S_IDLE: pop = rd_valid;
      S_CTRL:
      begin
        emit      = load;
        beat_next = '{sop: ctrl_idx == 3'h0, eop: ctrl_idx == CTRL_LAST, data: ctrl_byte};
      end
      S_DHDR:
      begin
        emit      = load;
        beat_next = '{sop: 1'b1, eop: 1'b0, data: DATA_TYPE};
      end
      S_DATA:
      begin
        if (load && rd_valid)
        begin
          pop = 1'b1;
          if (is_sample)
          begin
            emit      = in_clip;
            beat_next = '{sop: 1'b0, eop: last_kept, data: rd_word.data};
          end
          else
          begin
            // short field: close the open packet with one filler sample
            emit      = 1'b1;
            beat_next = '{sop: 1'b0, eop: 1'b1, data: PAD_SAMPLE};
          end
        end
      end
      default: pop = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= S_IDLE;
      ctrl_idx  <= '0;
      line_cnt  <= '0;
      pix_cnt   <= '0;
      fid_reg   <= 1'b0;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          if (rd_valid && rd_word.kind == K_START)
          begin
            fid_reg   <= rd_word.fid;
            ctrl_idx  <= '0;
            state_reg <= S_CTRL;
          end
        end
        S_CTRL:
        begin
          if (load)
          begin
            ctrl_idx <= ctrl_idx + 3'h1;
            if (ctrl_idx == CTRL_LAST)
            begin
              state_reg <= S_DHDR;
            end
          end
        end
        S_DHDR:
        begin
          if (load)
          begin
            line_cnt  <= '0;
            pix_cnt   <= '0;
            state_reg <= S_DATA;
          end
        end
        S_DATA:
        begin
          if (load && rd_valid)
          begin
            if (is_sample)
            begin
              if (pix_cnt == 11'(LINE_SAMPLES - 1))
              begin
                pix_cnt  <= '0;
                line_cnt <= line_cnt + 8'h01;
              end
              else
              begin
                pix_cnt <= pix_cnt + 11'h001;
              end
              if (last_kept)
              begin
                state_reg <= S_IDLE;
              end
            end
            else if (rd_word.kind == K_START)
            begin
              fid_reg   <= rd_word.fid;
              ctrl_idx  <= '0;
              state_reg <= S_CTRL;
            end
            else
            begin
              state_reg <= S_IDLE;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      vo_valid_reg <= 1'b0;
      vo_beat_reg  <= '0;
    end
    else if (load)
    begin
      vo_valid_reg <= emit;
      vo_beat_reg  <= beat_next;
    end
  end

  assign vo_valid_o = vo_valid_reg;
  assign vo_beat_o  = vo_beat_reg;

  // ---------------- checks ----------------
  a_hold_stall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    vo_valid_o && !vo_ready_i |=> vo_valid_o && $stable(vo_beat_o))
    else $error("output beat changed while stalled");

  a_ctrl_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == S_CTRL && load && ctrl_idx == 3'h0
    |=> vo_valid_o && vo_beat_o.sop && vo_beat_o.data == CTRL_TYPE)
    else $error("control packet did not open the field");

  a_sample_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pop && state_reg == S_DATA && is_sample && in_clip
    |=> vo_valid_o && vo_beat_o.data == $past(rd_word.data))
    else $error("active sample altered");

  a_clip_top: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pop && state_reg == S_DATA && is_sample && line_cnt < 8'(CLIP_TOP) |=> !vo_valid_o)
    else $error("sample above clip rectangle emitted");

  a_clip_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pop && state_reg == S_DATA && is_sample && last_kept
    |=> vo_beat_o.eop && state_reg == S_IDLE)
    else $error("field not closed at last clipped sample");

  a_blank_drop: assert property (@(posedge pix_clk_i) disable iff (!link_rst_n)
    wr_valid && wr_word.kind == K_SAMPLE
    |-> wr_word.data != TRS_ONES && wr_word.data != TRS_ZEROS)
    else $error("timing code pushed as sample");

  a_sav_active: assert property (@(posedge pix_clk_i) disable iff (!link_rst_n)
    sav_now |-> ##4 active_reg)
    else $error("active window not opened after line start");

  a_gate_start: assert property (@(posedge pix_clk_i) disable iff (!link_rst_n)
    !start_sync && !open_reg |-> !wr_valid)
    else $error("capture before start");

  a_ovf_drop: assert property (@(posedge pix_clk_i) disable iff (!link_rst_n)
    wr_valid && !wr_ready && wr_word.kind == K_SAMPLE |=> !open_reg ##1 !wr_valid || !active_reg || open_reg)
    else $error("field not dropped after overflow");

endmodule

// ==== rtl/vin_cdc_fifo.sv ====
module vin_cdc_fifo #(
  parameter int W  = 11,
  parameter int AW = 11
) (
  // write side
  input  wire logic         wr_clk_i,
  input  wire logic         wr_rst_n_i,
  input  wire logic         wr_valid_i,
  input  wire logic [W-1:0] wr_data_i,
  output logic              wr_ready_o,
  // read side
  input  wire logic         rd_clk_i,
  input  wire logic         rd_rst_n_i,
  output logic              rd_valid_o,
  output logic [W-1:0]      rd_data_o,
  input  wire logic         rd_ready_i
);

  logic [W-1:0] mem [2**AW];
  logic [AW:0]  wbin, wgray, rbin, rgray;
  logic [AW:0]  wg_meta, wg_sync, rg_meta, rg_sync;
  logic [AW:0]  wbin_next, rbin_next;
  logic         push, pop;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // full when write pointer is one lap ahead of the synced read pointer
  assign wr_ready_o = wgray != {~rg_sync[AW:AW-1], rg_sync[AW-2:0]};
  assign rd_valid_o = rgray != wg_sync;
  assign push       = wr_valid_i && wr_ready_o;
  assign pop        = rd_valid_o && rd_ready_i;
  assign wbin_next  = wbin + (AW+1)'(push);
  assign rbin_next  = rbin + (AW+1)'(pop);
  assign rd_data_o  = mem[rbin[AW-1:0]];

  always_ff @(posedge wr_clk_i)
  begin
    if (push)
    begin
      mem[wbin[AW-1:0]] <= wr_data_i;
    end
  end

  always_ff @(posedge wr_clk_i)
  begin
    if (!wr_rst_n_i)
    begin
      wbin    <= '0;
      wgray   <= '0;
      rg_meta <= '0;
      rg_sync <= '0;
    end
    else
    begin
      wbin    <= wbin_next;
      wgray   <= to_gray(wbin_next);
      rg_meta <= rgray;
      rg_sync <= rg_meta;
    end
  end

  always_ff @(posedge rd_clk_i)
  begin
    if (!rd_rst_n_i)
    begin
      rbin    <= '0;
      rgray   <= '0;
      wg_meta <= '0;
      wg_sync <= '0;
    end
    else
    begin
      rbin    <= rbin_next;
      rgray   <= to_gray(rbin_next);
      wg_meta <= wgray;
      wg_sync <= wg_meta;
    end
  end

endmodule

// ==== rtl/vin_pkg.sv ====
package vin_pkg;

  // pixel lane and field geometry
  localparam int PIX_W         = 8;
  localparam int ACTIVE_PIXELS = 720;
  localparam int EVEN_LINES    = 244;
  localparam int ODD_LINES     = 243;
  localparam int SAMPLES_PER_PX = 2;
  localparam int LINE_SAMPLES  = ACTIVE_PIXELS * SAMPLES_PER_PX;

  // clip rectangle
  localparam int CLIP_WIDTH  = 720;
  localparam int CLIP_HEIGHT = 240;
  localparam int CLIP_TOP    = 3;
  localparam int CLIP_LAST   = CLIP_TOP + CLIP_HEIGHT - 1;
  localparam int CLIP_SAMPLES = CLIP_WIDTH * SAMPLES_PER_PX;

  // timing reference code
  localparam logic [7:0] TRS_ONES  = 8'hFF;
  localparam logic [7:0] TRS_ZEROS = 8'h00;
  localparam int XY_F = 6;
  localparam int XY_V = 5;
  localparam int XY_H = 4;

  // output packet layout
  localparam logic [7:0]  CTRL_TYPE  = 8'h0F;
  localparam logic [7:0]  DATA_TYPE  = 8'h00;
  localparam logic [7:0]  PAD_SAMPLE = 8'h80;
  localparam logic [15:0] OUT_WIDTH  = 16'(CLIP_WIDTH);
  localparam logic [7:0]  OUT_HEIGHT = 8'(CLIP_HEIGHT);
  localparam logic [2:0]  CTRL_LAST  = 3'h4;

  typedef enum logic [1:0] {
    K_START  = 2'h0,
    K_SAMPLE = 2'h1,
    K_END    = 2'h2
  } kind_t;

  typedef struct packed {
    kind_t      kind;
    logic       fid;
    logic [7:0] data;
  } link_word_t;

  typedef struct packed {
    logic       sop;
    logic       eop;
    logic [7:0] data;
  } beat_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_CTRL = 4'h2,
    S_DHDR = 4'h4,
    S_DATA = 4'h8
  } sys_state_t;

endpackage
